// ==== rtl/sbd_pkg.sv ====
// Constants shared by the single-wire background debug port and its command FIFO.
// Assumes a single 200 MHz clock domain; all bit-time figures count debug bit clock ticks.
`default_nettype none
package sbd_pkg;
    // Bit-time figures, in debug bit clock ticks, then INIT_CYCLES in clk cycles.
    localparam int unsigned BIT_TICKS      = 16;
    localparam int unsigned SAMPLE_TICKS   = 10;
    localparam int unsigned SPEEDUP_TICK   = 7;
    localparam int unsigned ZERO_LOW_TICKS = 13;
    localparam int unsigned TIMEOUT_TICKS  = 512;
    localparam int unsigned STEAL_TICKS    = 128;
    localparam int unsigned INIT_CYCLES    = 2;

    // Frame field widths and command FIFO depth.
    localparam int unsigned OPC_BITS  = 8;
    localparam int unsigned WORD_BITS = 16;
    localparam int unsigned CMD_WIDTH = OPC_BITS + WORD_BITS;
    localparam int unsigned CMD_DEPTH = 16;

    // Hardware command opcodes.
    localparam logic [7:0] OPC_BACKGROUND   = 8'h90;
    localparam logic [7:0] OPC_READ_BYTE    = 8'hE0;
    localparam logic [7:0] OPC_READ_WORD    = 8'hE8;
    localparam logic [7:0] OPC_DBG_RD_BYTE  = 8'hE4;
    localparam logic [7:0] OPC_DBG_RD_WORD  = 8'hEC;
    localparam logic [7:0] OPC_WRITE_BYTE   = 8'hC0;
    localparam logic [7:0] OPC_WRITE_WORD   = 8'hC8;
    localparam logic [7:0] OPC_DBG_WR_BYTE  = 8'hC4;
    localparam logic [7:0] OPC_DBG_WR_WORD  = 8'hCC;
    // Firmware command opcodes.
    localparam logic [7:0] OPC_FW_RD_FIRST  = 8'h62;
    localparam logic [7:0] OPC_FW_RD_LAST   = 8'h67;
    localparam logic [7:0] OPC_FW_WR_FIRST  = 8'h42;
    localparam logic [7:0] OPC_FW_WR_LAST   = 8'h47;
    localparam logic [7:0] OPC_GO           = 8'h08;
    localparam logic [7:0] OPC_SINGLE_STEP  = 8'h10;
    localparam logic [7:0] OPC_TAG_RESUME   = 8'h18;

    // Debug ROM window while background mode is active.
    localparam logic [15:0] DEBUG_ROM_FIRST = 16'hFF20;
    localparam logic [15:0] DEBUG_ROM_LAST  = 16'hFFFF;

    // Byte-lane enables: high lane holds even addresses, low lane odd ones.
    localparam logic [1:0] LANE_WORD = 2'h3;
    localparam logic [1:0] LANE_ODD  = 2'h1;
    localparam logic [1:0] LANE_EVEN = 2'h2;

    typedef enum logic [2:0] {
        CL_NONE  = 3'h0,
        CL_HW_RD = 3'h1,
        CL_HW_WR = 3'h2,
        CL_BKGND = 3'h3,
        CL_FW_RD = 3'h4,
        CL_FW_WR = 3'h5,
        CL_FW_CT = 3'h6
    } sbd_class_t;
endpackage
`default_nettype wire

// ==== rtl/sbd_stream_if.sv ====
// Valid/ready stream carrier between the debug port and its command FIFO.
// Assumes both ends sit on the same clock.
`default_nettype none
interface sbd_stream_if #(parameter int unsigned WIDTH = 24);
    logic [WIDTH-1:0] data;
    logic             valid;
    logic             ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

// ==== rtl/sbd_fifo.sv ====
// Synchronous first-word-fall-through FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`default_nettype none
module sbd_fifo #(
    parameter int unsigned WIDTH = 24,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic  clk,
    input  wire logic  reset_n,
    sbd_stream_if.snk  wr,
    sbd_stream_if.src  rd
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp_r;
    logic [AW-1:0]    rp_r;
    logic [AW:0]      cnt_r;

    wire full  = (cnt_r == (AW+1)'(DEPTH));
    wire empty = (cnt_r == '0);
    wire push  = wr.valid && !full;
    wire pop   = rd.ready && !empty;

    assign wr.ready = !full;
    assign rd.valid = !empty;
    assign rd.data  = mem[rp_r];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_r] <= wr.data;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            wp_r  <= push ? wp_r + 1'b1 : wp_r;
            rp_r  <= pop ? rp_r + 1'b1 : rp_r;
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// ==== rtl/sbd_debug_port.sv ====
// Single-wire background debug port: bit engine, command framing, bus cycle stealing
// and background-mode control. Assumes memory, firmware and CPU handshakes are on clk.
//
// How it works
// R01: Special single-chip mode starts in background mode.
// R02: Host starts each bit with falling edge.
// R03: MSB first, sixteen debug clocks per bit.
// R04: 512 quiet debug clocks clear the command.
// R05: Bit start seen late; sample ten later.
// R06: Host holds low two cycles, releases early.
// R07: Sending one: speed-up pulse at seven.
// R08: Sending zero: low thirteen, then drive high.
// R09: Host samples about ten cycles in.
// R10: Hardware commands steal bus after 128.
// R11: Opcode 90 enters background if permitted.
// R12: E0, E8, E4 read with address.
// R13: C8, C4, CC write address then data.
// R14: Byte lane by address parity; words aligned.
// R15: Debug map switched in only during access.
// R16: Firmware commands only in background; ROM window.
// R17: Firmware reads 62 to 67 return data.
// R18: Firmware writes 42 to 47 take data.
// R19: 08 resumes, 10 steps, 18 tags.
// R20: Opcode byte then address and/or data word.
// R21: Host waits 150 clocks on hardware commands.
// R22: Host waits 32 clocks on firmware commands.
// R23: Unpermitted background request just keeps running.
// R24: Clock select picks base or bus clock.
// R25: Host waits 64 clocks after resume.
// R26: After time-out next edge starts opcode.
`default_nettype none
module sbd_debug_port
    import sbd_pkg::*;
#(
    parameter int unsigned FIFO_DEPTH = CMD_DEPTH
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        debug_line_in,
    output logic             debug_line_out,
    output logic             debug_line_oe_n,
    input  wire logic        special_single_chip,
    input  wire logic        firmware_permit_bit,
    input  wire logic        debug_clock_select,
    input  wire logic        bus_clock_slower,
    input  wire logic        bus_e_clock_tick,
    input  wire logic        bus_free,
    output logic             mem_req,
    output logic             mem_we,
    output logic [15:0]      mem_addr,
    output logic [15:0]      mem_wdata,
    output logic [1:0]       mem_lane,
    output logic             mem_debug_map,
    input  wire logic [15:0] mem_rdata,
    input  wire logic        mem_ack,
    output logic             cpu_freeze,
    input  wire logic [15:0] cpu_addr,
    output logic             debug_rom_hit,
    output logic             background_active,
    output logic             tagging_enable,
    input  wire logic        user_instr_done,
    output logic             fw_cmd_valid,
    output logic [23:0]      fw_cmd_data,
    input  wire logic        fw_cmd_ready,
    input  wire logic [15:0] fw_rdata,
    input  wire logic        fw_rdata_valid
);
    typedef enum logic [2:0] {
        SB_WAIT = 3'b001,
        SB_RX   = 3'b010,
        SB_TX   = 3'b100
    } sbd_bit_t;

    typedef enum logic [6:0] {
        FP_OP   = 7'b0000001,
        FP_ADDR = 7'b0000010,
        FP_DIN  = 7'b0000100,
        FP_MEM  = 7'b0001000,
        FP_PUSH = 7'b0010000,
        FP_FWRD = 7'b0100000,
        FP_DOUT = 7'b1000000
    } sbd_phase_t;

    function automatic sbd_class_t classify(input logic [7:0] op);
        unique case (1'b1)
            op == OPC_READ_BYTE || op == OPC_READ_WORD || op == OPC_DBG_RD_BYTE || op == OPC_DBG_RD_WORD:
                return CL_HW_RD;
            op == OPC_WRITE_BYTE || op == OPC_WRITE_WORD || op == OPC_DBG_WR_BYTE || op == OPC_DBG_WR_WORD:
                return CL_HW_WR;
            op == OPC_BACKGROUND:
                return CL_BKGND;
            op >= OPC_FW_RD_FIRST && op <= OPC_FW_RD_LAST:
                return CL_FW_RD;
            op >= OPC_FW_WR_FIRST && op <= OPC_FW_WR_LAST:
                return CL_FW_WR;
            op == OPC_GO || op == OPC_SINGLE_STEP || op == OPC_TAG_RESUME:
                return CL_FW_CT;
            default:
                return CL_NONE;
        endcase
    endfunction

    // Line synchroniser; only stage 2 and later feed logic.
    logic line_s1_r, line_s2_r, line_s3_r;
    logic strap_s1_r, strap_s2_r;
    logic [1:0] init_cnt_r;

    sbd_bit_t   bstate_r;
    sbd_phase_t phase_r;
    sbd_class_t class_r;
    logic [4:0]  tcnt_r;
    logic [4:0]  bits_r;
    logic [15:0] shreg_r;
    logic [7:0]  opcode_r;
    logic        tx_bit_r;
    logic [9:0]  to_cnt_r;
    logic [7:0]  steal_cnt_r;
    logic        fw_ok_r;
    logic        trace_pend_r;
    logic        line_out_nxt, line_oe_n_nxt;

    // Debug bit clock: base clock every cycle, or the bus clock when chosen or slower.
    wire clk_sel_bus = debug_clock_select || bus_clock_slower; // R24
    wire tick        = clk_sel_bus ? bus_e_clock_tick : 1'b1; // R24
    wire host_fall   = line_s3_r && !line_s2_r; // R02 R05

    wire busy      = (phase_r == FP_MEM) || (phase_r == FP_PUSH) || (phase_r == FP_FWRD);
    wire timeout   = tick && !busy && (to_cnt_r == 10'(TIMEOUT_TICKS - 1)); // R04
    wire rx_done   = (bstate_r == SB_RX) && tick && (tcnt_r == 5'(SAMPLE_TICKS - 1)); // R05
    wire tx_done   = (bstate_r == SB_TX) && tick && (tcnt_r == 5'(BIT_TICKS - 1)); // R03
    wire bit_done  = rx_done || tx_done;
    wire [15:0] sh_nxt   = {shreg_r[14:0], line_s2_r}; // R03
    wire [4:0]  bits_nxt = bits_r + 5'h1;
    wire op_done   = bit_done && (phase_r == FP_OP) && (bits_nxt == 5'(OPC_BITS)); // R20
    wire word_done = bit_done && (bits_nxt == 5'(WORD_BITS));
    wire [7:0] op_new  = sh_nxt[7:0];
    wire sbd_class_t cl_new = classify(op_new);
    wire is_dbg_map = (opcode_r == OPC_DBG_RD_BYTE) || (opcode_r == OPC_DBG_RD_WORD)
                   || (opcode_r == OPC_DBG_WR_BYTE) || (opcode_r == OPC_DBG_WR_WORD);
    wire is_word    = opcode_r[3];
    wire grant      = (phase_r == FP_MEM) && !mem_req
                   && (bus_free || steal_cnt_r == 8'(STEAL_TICKS)); // R10
    wire [15:0] lane_mask = {{8{mem_lane[1]}}, {8{mem_lane[0]}}};

    sbd_stream_if #(.WIDTH(CMD_WIDTH)) cmd_in ();
    sbd_stream_if #(.WIDTH(CMD_WIDTH)) cmd_out ();
    wire pushed = cmd_in.valid && cmd_in.ready;
    wire bkgnd_req = op_done && (cl_new == CL_BKGND);
    wire bg_enter  = (bkgnd_req && firmware_permit_bit) || (trace_pend_r && user_instr_done); // R11 R19
    wire bg_leave  = pushed && (class_r == CL_FW_CT); // R19

    assign cmd_in.valid = (phase_r == FP_PUSH);
    assign cmd_in.data  = {opcode_r, shreg_r}; // R20
    assign cmd_out.ready = fw_cmd_ready;

    sbd_fifo #(.WIDTH(CMD_WIDTH), .DEPTH(FIFO_DEPTH)) u_cmd_fifo (
        .clk     (clk),
        .reset_n (reset_n),
        .wr      (cmd_in),
        .rd      (cmd_out)
    );
    assign fw_cmd_valid = cmd_out.valid;
    assign fw_cmd_data  = cmd_out.data;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            line_s1_r  <= 1'b1;
            line_s2_r  <= 1'b1;
            line_s3_r  <= 1'b1;
            strap_s1_r <= 1'b0;
            strap_s2_r <= 1'b0;
        end else begin
            line_s1_r  <= debug_line_in;
            line_s2_r  <= line_s1_r;
            line_s3_r  <= line_s2_r;
            strap_s1_r <= special_single_chip;
            strap_s2_r <= strap_s1_r;
        end
    end

    // A sent zero makes a fresh fall on the line; the bit engine ignores it while sending.
    always_comb begin
        line_out_nxt  = 1'b1;
        line_oe_n_nxt = 1'b1;
        if (bstate_r == SB_TX) begin
            if (tx_bit_r) begin
                line_oe_n_nxt = !(tcnt_r == 5'(SPEEDUP_TICK)); // R07
            end else if (tcnt_r < 5'(ZERO_LOW_TICKS)) begin
                line_out_nxt  = 1'b0; // R08
                line_oe_n_nxt = 1'b0;
            end else begin
                line_oe_n_nxt = !(tcnt_r == 5'(ZERO_LOW_TICKS)); // R08
            end
        end
    end

    // Bit engine.
    always_ff @(posedge clk) begin
        if (!reset_n || timeout) begin
            bstate_r <= SB_WAIT; // R26
            tcnt_r   <= '0;
            tx_bit_r <= 1'b0;
        end else begin
            unique case (bstate_r)
                SB_WAIT: begin
                    tcnt_r <= '0;
                    if (host_fall && phase_r == FP_DOUT) begin
                        bstate_r <= SB_TX;
                        tx_bit_r <= shreg_r[15]; // R03
                    end else if (host_fall && !busy) begin
                        bstate_r <= SB_RX;
                    end
                end
                SB_RX, SB_TX: begin
                    tcnt_r <= tick ? tcnt_r + 5'h1 : tcnt_r;
                    if (bit_done) begin
                        bstate_r <= SB_WAIT;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n || host_fall) begin
            to_cnt_r <= '0;
        end else if (tick) begin
            to_cnt_r <= to_cnt_r + 10'h1; // R04
        end
    end

    // Command framing.
    always_ff @(posedge clk) begin
        if (!reset_n || timeout) begin
            phase_r  <= FP_OP; // R04 R26
            class_r  <= CL_NONE;
            opcode_r <= '0;
            bits_r   <= '0;
            shreg_r  <= '0;
            fw_ok_r  <= 1'b0;
        end else begin
            if (bit_done) begin
                shreg_r <= (bstate_r == SB_TX) ? {shreg_r[14:0], 1'b0} : sh_nxt;
                bits_r  <= (op_done || word_done) ? 5'h0 : bits_nxt;
            end
            unique case (phase_r)
                FP_OP: if (op_done) begin
                    opcode_r <= op_new;
                    class_r  <= cl_new;
                    fw_ok_r  <= background_active; // R16
                    unique case (cl_new)
                        CL_HW_RD, CL_HW_WR: phase_r <= FP_ADDR; // R12 R13
                        CL_FW_WR:           phase_r <= FP_DIN; // R18
                        CL_FW_RD, CL_FW_CT: phase_r <= background_active ? FP_PUSH : FP_OP; // R16 R17
                        default:            phase_r <= FP_OP; // R11
                    endcase
                end
                FP_ADDR: if (word_done) begin
                    phase_r <= (class_r == CL_HW_RD) ? FP_MEM : FP_DIN;
                end
                FP_DIN: if (word_done) begin
                    phase_r <= (class_r == CL_HW_WR) ? FP_MEM : (fw_ok_r ? FP_PUSH : FP_OP); // R16 R18
                end
                FP_MEM: if (mem_ack && mem_req) begin
                    shreg_r <= mem_rdata & lane_mask; // R14
                    phase_r <= mem_we ? FP_OP : FP_DOUT;
                end
                FP_PUSH: if (pushed) begin
                    phase_r <= (class_r == CL_FW_RD) ? FP_FWRD : FP_OP;
                end
                FP_FWRD: if (fw_rdata_valid) begin
                    shreg_r <= fw_rdata; // R17
                    phase_r <= FP_DOUT;
                end
                FP_DOUT: if (word_done) begin
                    phase_r <= FP_OP; // R20
                end
            endcase
        end
    end

    // Memory access with cycle stealing.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            mem_req       <= 1'b0;
            mem_we        <= 1'b0;
            mem_addr      <= '0;
            mem_wdata     <= '0;
            mem_lane      <= LANE_WORD;
            mem_debug_map <= 1'b0;
            cpu_freeze    <= 1'b0;
            steal_cnt_r   <= '0;
        end else begin
            if (phase_r == FP_ADDR && word_done) begin
                mem_addr <= is_word ? {sh_nxt[15:1], 1'b0} : sh_nxt; // R14
                mem_lane <= is_word ? LANE_WORD : (sh_nxt[0] ? LANE_ODD : LANE_EVEN); // R14
                mem_we   <= (class_r == CL_HW_WR);
            end
            if (phase_r == FP_DIN && word_done) begin
                mem_wdata <= sh_nxt; // R13
            end
            if (grant) begin
                mem_req       <= 1'b1; // R10
                mem_debug_map <= is_dbg_map; // R15
                cpu_freeze    <= !bus_free; // R10
                steal_cnt_r   <= '0;
            end else if (mem_req && mem_ack) begin
                mem_req       <= 1'b0;
                mem_debug_map <= 1'b0; // R15
                cpu_freeze    <= 1'b0;
            end else if (phase_r == FP_MEM && !mem_req && tick) begin
                steal_cnt_r <= steal_cnt_r + 8'h1; // R10
            end
        end
    end

    // Background mode control; the strap is taken only after reset release.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            init_cnt_r        <= '0;
            background_active <= 1'b0;
            tagging_enable    <= 1'b0;
            trace_pend_r      <= 1'b0;
        end else begin
            if (init_cnt_r != 2'(INIT_CYCLES + 1)) begin
                init_cnt_r <= init_cnt_r + 2'h1;
            end
            if (init_cnt_r == 2'(INIT_CYCLES) && strap_s2_r) begin
                background_active <= 1'b1; // R01
            end else if (bg_enter) begin
                background_active <= 1'b1; // R11 R23
                tagging_enable    <= 1'b0;
            end else if (bg_leave) begin
                background_active <= 1'b0; // R19
                tagging_enable    <= (opcode_r == OPC_TAG_RESUME);
            end
            if (bg_leave) begin
                trace_pend_r <= (opcode_r == OPC_SINGLE_STEP);
            end else if (user_instr_done) begin
                trace_pend_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            debug_line_out  <= 1'b1;
            debug_line_oe_n <= 1'b1;
            debug_rom_hit   <= 1'b0;
        end else begin
            debug_line_out  <= line_out_nxt;
            debug_line_oe_n <= line_oe_n_nxt;
            debug_rom_hit   <= background_active && cpu_addr >= DEBUG_ROM_FIRST
                            && cpu_addr <= DEBUG_ROM_LAST; // R16
        end
    end
endmodule
`default_nettype wire

// ==== verification/sbd_debug_port_asserts.sv ====
// Pin-level checker bound into every debug port.
// Assumes base-clock pacing: one debug tick per clk.
`default_nettype none
module sbd_debug_port_asserts
    import sbd_pkg::*;
#(parameter int unsigned FIFO_DEPTH = CMD_DEPTH) (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        debug_line_in,
    input wire logic        debug_line_out,
    input wire logic        debug_line_oe_n,
    input wire logic        special_single_chip,
    input wire logic        bus_free,
    input wire logic        mem_req,
    input wire logic [15:0] mem_addr,
    input wire logic [1:0]  mem_lane,
    input wire logic        mem_debug_map,
    input wire logic        mem_ack,
    input wire logic        cpu_freeze,
    input wire logic [15:0] cpu_addr,
    input wire logic        debug_rom_hit,
    input wire logic        background_active
);
    logic       line_q;
    logic [7:0] since_r;
    logic [4:0] low_r;
    wire        drv_low = !debug_line_oe_n && !debug_line_out;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    always_ff @(posedge clk) begin
        line_q <= debug_line_in;
        since_r <= (!reset_n || (line_q && !debug_line_in)) ? 8'h00 : since_r + {7'h00, since_r != 8'hFF};
        low_r <= (reset_n && drv_low) ? low_r + 5'h01 : 5'h00;
    end
    AST_ZERO_LOW_SPAN: assert property ((low_r != 5'h00) && !drv_low |->
        (low_r == 5'h0D) && !debug_line_oe_n && debug_line_out) else $error("zero bit low span wrong");
    AST_ZERO_START: assert property ($fell(debug_line_oe_n) && !debug_line_out |->
        since_r inside {[8'h02:8'h06]}) else $error("zero bit starts at wrong time");
    AST_SPEEDUP: assert property ($fell(debug_line_oe_n) && debug_line_out |->
        since_r inside {[8'h09:8'h0D]} ##1 debug_line_oe_n) else $error("speed-up pulse misplaced");
    AST_LANE: assert property (mem_req |-> mem_lane != 2'h0 && (mem_lane != LANE_WORD || !mem_addr[0]))
        else $error("bad lane or unaligned word");
    AST_DBG_MAP: assert property (mem_debug_map |-> mem_req)
        else $error("debug map outside access");
    AST_REQ_HOLD: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
        else $error("request dropped early");
    AST_STEAL: assert property ($rose(mem_req) && !cpu_freeze |-> $past(bus_free))
        else $error("access without free cycle");
    AST_ROM_HIT: assert property (debug_rom_hit == $past(background_active && cpu_addr >= DEBUG_ROM_FIRST))
        else $error("rom window decode wrong");
    AST_RESET_BG: assert property ($rose(reset_n) && special_single_chip |-> ##[2:5] background_active)
        else $error("no background after reset");
endmodule
bind sbd_debug_port sbd_debug_port_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.*);
`default_nettype wire

// ==== verification/sbd_host_model.sv ====
// Host model on the debug line.
// Assumes a pull-up on the line; a bit takes twenty-one clk.
`default_nettype none
module sbd_host_model (
    input  wire logic clk,
    input  wire logic line,
    output var logic  pull_low
);
    timeunit 1ns;
    timeprecision 100ps;
    initial pull_low = 1'b0;
    // A one is released long before the device samples; a zero is held past it.
    task automatic send_bit(input logic b);
        @(posedge clk);
        #1 pull_low = 1'b1;
        repeat (b ? 4 : 14) @(posedge clk);
        #1 pull_low = 1'b0;
        repeat (b ? 16 : 6) @(posedge clk);
    endtask
    task automatic send_opc(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) send_bit(v[i]);
    endtask
    task automatic send_word(input logic [15:0] v);
        for (int i = 15; i >= 0; i--) send_bit(v[i]);
    endtask
    task automatic recv_word(output logic [15:0] v);
        for (int i = 15; i >= 0; i--) begin
            @(posedge clk);
            #1 pull_low = 1'b1;
            repeat (2) @(posedge clk);
            #1 pull_low = 1'b0;
            repeat (8) @(posedge clk);
            #1 v[i] = line;
            repeat (10) @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

// ==== verification/sbd_debug_port_test.sv ====
// Bench for the debug port with host model and stubs.
// Assumes base-clock pacing and the strap held high.
`default_nettype none
module sbd_debug_port_test
    import sbd_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk, line_out, line_oe_n, mem_req, mem_we, mem_dbg, mem_ack, freeze, rom_hit, bg, tag;
    logic        fw_valid, fw_rv, host_low, rd_pop, last_we, last_dbg, freeze_seen;
    logic        reset_n = 1'b0, permit = 1'b1, bus_free = 1'b1, fw_ready = 1'b1, step_done = 1'b0, clk_sel = 1'b0;
    logic [1:0]  mem_lane, last_lane;
    logic [15:0] mem_addr, mem_wdata, mem_rdata, last_addr, last_wdata, cpu_addr = 16'h0000;
    logic [23:0] fw_data, popped[$];
    int          mismatches, num_checks;
    wire         line = !(host_low || (!line_oe_n && !line_out));
    sbd_debug_port u_dut (.clk(clk), .reset_n(reset_n),
        .debug_line_in(line), .debug_line_out(line_out), .debug_line_oe_n(line_oe_n),
        .special_single_chip(1'b1), .firmware_permit_bit(permit), .debug_clock_select(clk_sel),
        .bus_clock_slower(1'b0), .bus_e_clock_tick(1'b0), .bus_free(bus_free), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_lane(mem_lane),
        .mem_debug_map(mem_dbg), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .cpu_freeze(freeze),
        .cpu_addr(cpu_addr), .debug_rom_hit(rom_hit), .background_active(bg), .tagging_enable(tag),
        .user_instr_done(step_done), .fw_cmd_valid(fw_valid), .fw_cmd_data(fw_data),
        .fw_cmd_ready(fw_ready), .fw_rdata(16'hA5C3), .fw_rdata_valid(fw_rv));
    sbd_host_model u_host (.clk(clk), .line(line), .pull_low(host_low));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Memory and firmware stubs answer one clk late.
    always @(posedge clk) begin
        freeze_seen = freeze_seen || freeze;
        rd_pop = fw_valid && fw_ready && fw_data[23:20] == 4'h6;
        if (fw_valid && fw_ready)
            popped.push_back(fw_data);
        if (mem_req && mem_ack)
            {last_we, last_dbg, last_lane, last_addr, last_wdata} = {mem_we, mem_dbg, mem_lane, mem_addr, mem_wdata};
        #1;
        mem_ack = mem_req && !mem_ack;
        mem_rdata = ~mem_addr;
        fw_rv = rd_pop;
    end
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
            mismatches++;
        end
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic hw_write(input logic [7:0] opc, input logic [15:0] a, input logic [15:0] d);
        u_host.send_opc(opc);
        u_host.send_word(a);
        u_host.send_word(d);
        wait_clk(160);
        check({4'h0, last_we, last_dbg, last_lane, last_addr},
              {5'h01, opc[2], (opc[3] ? 2'h3 : {!a[0], a[0]}), a[15:1], a[0] & !opc[3]});
        check(24'(last_wdata), 24'(d));
    endtask
    task automatic hw_read(input logic [7:0] opc, input logic [15:0] a);
        logic [15:0] v;
        u_host.send_opc(opc);
        u_host.send_word(a);
        wait_clk(160);
        u_host.recv_word(v);
        check({6'h00, last_dbg, last_we, v},
              {6'h00, opc[2], 1'b0, ~{a[15:1], a[0] & !opc[3]} & (opc[3] ? 16'hFFFF : {{8{!a[0]}}, {8{a[0]}}})});
    endtask
    task automatic t_hw();
        hw_write(8'hC8, 16'h1235, 16'hBEEF);
        hw_write(8'hC4, 16'h1237, 16'h0012);
        hw_write(8'hC4, 16'hFF02, 16'h3400);
        hw_write(8'hCC, 16'h2001, 16'hCAFE);
        hw_read(8'hE0, 16'h3456);
        hw_read(8'hE0, 16'h3457);
        hw_read(8'hE8, 16'h3459);
        hw_read(8'hE4, 16'hFF01);
    endtask
    task automatic t_steal();
        bus_free = 1'b0;
        freeze_seen = 1'b0;
        hw_write(8'hC8, 16'h4000, 16'h1111);
        check(24'(freeze_seen), 24'h1);
        bus_free = 1'b1;
    endtask
    task automatic t_timeout();
        for (int i = 0; i < 4; i++) u_host.send_bit(1'b1);
        wait_clk(600);
        hw_write(8'hC8, 16'h5002, 16'h2222);
    endtask
    task automatic t_fifo();
        fw_ready = 1'b0;
        popped.delete();
        for (int i = 0; i < 16; i++) begin
            u_host.send_opc(8'h42 + 8'(i % 6));
            u_host.send_word(16'(i));
            wait_clk(40);
        end
        check(24'(fw_valid), 24'h1);
        fw_ready = 1'b1;
        wait_clk(30);
        check(24'(popped.size()), 24'h10);
        foreach (popped[i]) check(popped[i], {8'h42 + 8'(i % 6), 16'(i)});
    endtask
    task automatic t_fw_read();
        logic [15:0] v;
        for (int i = 0; i < 6; i++) begin
            u_host.send_opc(8'h62 + 8'(i));
            wait_clk(40);
            u_host.recv_word(v);
            check({popped[$][23:16], v}, {8'h62 + 8'(i), 16'hA5C3});
        end
    endtask
    task automatic t_rom();
        cpu_addr = 16'hFF20;
        wait_clk(2);
        check(24'(rom_hit), 24'h1);
        cpu_addr = 16'hFF1F;
        wait_clk(2);
        check(24'(rom_hit), 24'h0);
    endtask
    task automatic send_ctrl(input logic [7:0] opc);
        u_host.send_opc(opc);
        wait_clk(80);
    endtask
    task automatic t_ctrl();
        send_ctrl(8'h08);
        check(24'(bg), 24'h0);
        permit = 1'b0;
        send_ctrl(8'h90);
        check(24'(bg), 24'h0);
        popped.delete();
        send_ctrl(8'h64);
        check(24'(popped.size()), 24'h0);
        permit = 1'b1;
        send_ctrl(8'h90);
        check(24'(bg), 24'h1);
        send_ctrl(8'h10);
        check(24'(bg), 24'h0);
        step_done = 1'b1;
        wait_clk(1);
        step_done = 1'b0;
        wait_clk(4);
        check(24'(bg), 24'h1);
        send_ctrl(8'h18);
        check(24'({bg, tag}), 24'h1);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        wait_clk(4);
        reset_n = 1'b1;
        wait_clk(8);
        check(24'(bg), 24'h1);
        t_hw();
        t_steal();
        t_timeout();
        t_rom();
        t_fifo();
        t_fw_read();
        t_ctrl();
        end_of_test();
    end
    initial begin
        repeat (60000) @(posedge clk);
        mismatches++;
        end_of_test();
    end
endmodule
`default_nettype wire
